// ==== verilog/sdmf_top.sv ====
// Mode feature, termination and calibration readout logic of the memory
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "sdmf_cfg.svh"
module sdmf_top (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic [2:0] s_axi_awprot_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic [2:0] s_axi_arprot_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Memory command pins from the controller
   input wire logic link_clk_i,
   input wire logic dram_reset_n_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [2:0] ba_i,
   input wire logic [13:0] addr_i,
   input wire logic on_die_termination_i,
   // Case temperature sensor, degrees C
   input wire logic [7:0] case_temp_i,
   // Data lines
   output logic [15:0] dq_o,
   output logic [15:0] dq_oe_o,
   // Refresh and termination state, array read strobe
   output logic refresh_double_o,
   output logic self_refresh_o,
   output logic [1:0] term_sel_o,
   output logic [1:0] term_wr_code_o,
   output logic array_read_o
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   localparam int PW = 29;
   logic [PW-1:0] pin_raw, pin_m_q, pin_s_q;
   logic [7:0] temp_m_q, temp_s_q;
   logic lclk_d1_q;
   assign pin_raw = {link_clk_i, dram_reset_n_i, cke_i, cs_n_i, ras_n_i,
                     cas_n_i, we_n_i, ba_i, addr_i, on_die_termination_i,
                     4'h0};

   // Sensor changes slowly, so per-bit sampling is tolerable
   always_ff @(posedge clock_i)
   begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      temp_m_q <= case_temp_i;
      temp_s_q <= temp_m_q;
      lclk_d1_q <= pin_s_q[28];
   end

   wire lclk_s = pin_s_q[28];
   wire lreset_n_s = pin_s_q[27];
   wire cke_s = pin_s_q[26];
   wire [3:0] cmd_s = pin_s_q[25:22];
   wire [2:0] ba_s = pin_s_q[21:19];
   wire [13:0] addr_s = pin_s_q[18:5];
   wire odt_s = pin_s_q[4];
   wire link_rise = lclk_s & ~lclk_d1_q;
   wire link_edge = lclk_s ^ lclk_d1_q;

   function automatic logic cmd_is(input logic [3:0] pins,
                                   input logic [2:0] code);
      cmd_is = ~pins[3] & (pins[2:0] == code);
   endfunction : cmd_is

   wire is_mrs = link_rise & cmd_is(cmd_s, `SDMF_CMD_MRS);
   wire is_ref = link_rise & cmd_is(cmd_s, `SDMF_CMD_REF);
   wire is_rd = link_rise & cmd_is(cmd_s, `SDMF_CMD_RD);
   wire is_wr = link_rise & cmd_is(cmd_s, `SDMF_CMD_WR);

   // ---------------------------------------------------------------
   // Software registers and AXI4-Lite slave
   // ---------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] stat_word;
   sdmf_pkg::sdmf_mr_t mr2_q, mr3_q;
   logic rate_double_q, hot_q, self_ref_q;

   wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
   wire w_take = s_axi_wvalid_i & s_axi_wready_o;
   wire aw_have = aw_hold_q | aw_take;
   wire w_have = w_hold_q | w_take;
   wire wr_go = aw_have & w_have & ~bvalid_q;
   wire [7:0] wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr_i;
   wire [31:0] wr_data = w_hold_q ? wdata_q : s_axi_wdata_i;
   wire [3:0] wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb_i;
   wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                          {8{wr_strb[1]}}, {8{wr_strb[0]}}};

   function automatic logic known(input logic [7:0] a);
      known = (a == `SDMF_OFF_CTRL) | (a == `SDMF_OFF_MR2) |
              (a == `SDMF_OFF_MR3) | (a == `SDMF_OFF_STAT);
   endfunction : known

   assign s_axi_awready_o = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready_o = ~w_hold_q & ~bvalid_q;
   assign s_axi_arready_o = ~rvalid_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;

   wire ar_take = s_axi_arvalid_i & ~rvalid_q;
   wire both_modes = mr2_q[`SDMF_MR2_ASR] & mr2_q[`SDMF_MR2_SRT];
   wire burst_busy;
   assign stat_word = {27'h0, both_modes, burst_busy, self_ref_q,
                       hot_q, rate_double_q};
   wire [31:0] rd_mux =
      (s_axi_araddr_i == `SDMF_OFF_CTRL) ? ctrl_q :
      (s_axi_araddr_i == `SDMF_OFF_MR2) ? {18'h0, mr2_q} :
      (s_axi_araddr_i == `SDMF_OFF_MR3) ? {18'h0, mr3_q} :
      (s_axi_araddr_i == `SDMF_OFF_STAT) ? stat_word : 32'h0;

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         ctrl_q <= `SDMF_CTRL_RST;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `SDMF_RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end
      else
      begin
         aw_hold_q <= aw_have & ~wr_go;
         w_hold_q <= w_have & ~wr_go;
         if (aw_take)
            awaddr_q <= s_axi_awaddr_i;
         if (w_take)
         begin
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
         end
         if (wr_go && wr_addr == `SDMF_OFF_CTRL)
            ctrl_q <= (ctrl_q & ~wr_mask) | (wr_data & wr_mask);
         if (wr_go)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= known(wr_addr) ? `SDMF_RESP_OKAY
                                      : `SDMF_RESP_DECERR;
         end
         else if (s_axi_bready_i)
            bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= `SDMF_RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= known(s_axi_araddr_i) ? `SDMF_RESP_OKAY
                                          : `SDMF_RESP_DECERR;
      end
      else if (s_axi_rready_i)
         rvalid_q <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Mode registers and refresh rate
   // ---------------------------------------------------------------
   wire asr_en = mr2_q[`SDMF_MR2_ASR];
   wire srt_en = mr2_q[`SDMF_MR2_SRT];
   // (RULE_04) switch early, with hysteresis against chatter
   wire hot_d = (temp_s_q > `SDMF_TEMP_UP) |
                (hot_q & (temp_s_q >= `SDMF_TEMP_DOWN));
   // (RULE_01) (RULE_02) (RULE_03) (RULE_05) (RULE_06) rate choice
   wire rate_d = srt_en | (asr_en & hot_d);

   always_ff @(posedge clock_i)
   begin
      // (RULE_18) link reset clears readout mode
      if (!rst_n_i || !lreset_n_s)
      begin
         mr2_q <= `SDMF_MR_RST;
         mr3_q <= `SDMF_MR_RST;
         self_ref_q <= 1'b0;
      end
      else
      begin
         if (is_mrs && ba_s == `SDMF_BA_MR2)
            mr2_q <= addr_s;
         if (is_mrs && ba_s == `SDMF_BA_MR3)
            mr3_q <= addr_s;
         if (is_ref && !cke_s)
            self_ref_q <= 1'b1;
         else if (link_rise && cke_s)
            self_ref_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         hot_q <= 1'b0;
         rate_double_q <= 1'b0;
      end
      else
      begin
         hot_q <= hot_d;
         rate_double_q <= rate_d;
      end
   end

   assign refresh_double_o = rate_double_q;
   assign self_refresh_o = self_ref_q;

   // ---------------------------------------------------------------
   // Termination
   // ---------------------------------------------------------------
   logic [4:0] wr_cnt_q;
   logic [1:0] term_q;
   wire [1:0] dyn_code = mr2_q[`SDMF_MR2_DYN];
   // (RULE_09) nonzero code enables
   wire dyn_en = (dyn_code != 2'h0);
   wire wr_active = (wr_cnt_q != 5'h00);
   wire wlvl = ctrl_q[`SDMF_CTRL_WLVL];
   // (RULE_10) (RULE_11) (RULE_12) termination choice
   wire [1:0] term_d =
      (wr_active && dyn_en && !wlvl) ? `SDMF_TERM_WR :
      (odt_s && ctrl_q[`SDMF_CTRL_NOM]) ? `SDMF_TERM_NOM : `SDMF_TERM_HIZ;

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i || !lreset_n_s)
      begin
         wr_cnt_q <= 5'h00;
         term_q <= `SDMF_TERM_HIZ;
      end
      else
      begin
         term_q <= term_d;
         if (is_wr)
            wr_cnt_q <= ctrl_q[`SDMF_CTRL_WL] + `SDMF_WR_HOLD;
         else if (link_rise && wr_active)
            wr_cnt_q <= wr_cnt_q - 5'h01;
      end
   end

   assign term_sel_o = term_q;
   assign term_wr_code_o = dyn_code;

   // ---------------------------------------------------------------
   // Calibration pattern readout
   // ---------------------------------------------------------------
   sdmf_burst_if bif ();
   logic [15:0] dq_q, oe_q;
   logic arr_q;
   wire [1:0] bmode = ctrl_q[`SDMF_CTRL_BM];
   // (RULE_15) (RULE_16) redirect reads when enabled
   wire mpr_en = mr3_q[`SDMF_MR3_EN];
   // (RULE_25) reserved selects drive zeros
   wire sel_cal = (mr3_q[`SDMF_MR3_SEL] == `SDMF_SEL_CAL);
   // (RULE_20) fixed or per-command chop
   wire chop = (bmode == `SDMF_BM_BC4) |
               ((bmode == `SDMF_BM_OTF) & ~addr_s[`SDMF_A_BC]);
   wire pat_go = is_rd & mpr_en & ctrl_q[`SDMF_CTRL_DLL] & ~burst_busy &
                 lreset_n_s;
   wire pat_bit = bif.beat_bit & sel_cal;

   assign bif.start = pat_go;
   assign bif.chop = chop;
   assign bif.upper = addr_s[`SDMF_A_UPPER];
   assign bif.lat = ctrl_q[`SDMF_CTRL_RL];
   assign bif.rise = link_rise;
   assign bif.edge_any = link_edge;
   assign burst_busy = bif.busy;

   sdmf_burst u_burst (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i & lreset_n_s),
      .bus (bif.ctl)
   );

   // (RULE_19) prime lanes or all lanes
   genvar ln;
   generate
      for (ln = 0; ln < 16; ln++)
      begin : g_lane
         wire prime = (ln == 0) || (ln == 8);
         always_ff @(posedge clock_i)
         begin
            if (!rst_n_i)
               dq_q[ln] <= 1'b0;
            else
               dq_q[ln] <= (prime || ctrl_q[`SDMF_CTRL_ALL]) & pat_bit;
         end
      end
   endgenerate

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         oe_q <= 16'h0000;
         arr_q <= 1'b0;
      end
      else
      begin
         oe_q <= {16{bif.beat_valid}};
         arr_q <= is_rd & ~mpr_en;
      end
   end

   assign dq_o = dq_q;
   assign dq_oe_o = oe_q;
   assign array_read_o = arr_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   AST_FORCED_RATE: // (RULE_06)
      assert property (srt_en |=> refresh_double_o)
      else $error("forced double rate not applied");
   AST_SINGLE_RATE: // (RULE_02)
      assert property (!srt_en && !asr_en |=> !refresh_double_o)
      else $error("single rate expected");
   AST_AUTO_HOT: // (RULE_03)
      assert property (asr_en && temp_s_q > `SDMF_TEMP_LIMIT
                       |=> refresh_double_o)
      else $error("automatic rate missed hot case");
   AST_NO_WR_TERM_LEVEL: // (RULE_12)
      assert property (wlvl |=> term_sel_o != `SDMF_TERM_WR)
      else $error("write termination during leveling");
   AST_HIZ_OUTSIDE: // (RULE_11)
      assert property (!wr_active && !ctrl_q[`SDMF_CTRL_NOM]
                       |=> term_sel_o == `SDMF_TERM_HIZ)
      else $error("termination not high impedance");
   AST_LINK_RESET: // (RULE_18)
      assert property (!lreset_n_s |=> !mr3_q[`SDMF_MR3_EN] && !burst_busy)
      else $error("reset ignored in readout mode");
   AST_PRIME_LOW: // (RULE_19)
      assert property (!$past(ctrl_q[`SDMF_CTRL_ALL])
                       |-> dq_o[7:1] == 7'h00 && dq_o[15:9] == 7'h00)
      else $error("non-prime lane driven");
   AST_NORMAL_READ: // (RULE_15)
      assert property (is_rd && !mpr_en && !burst_busy
                       |=> !burst_busy ##0 array_read_o)
      else $error("normal read went to pattern");
   AST_PATTERN_START: // (RULE_24)
      assert property (pat_go && ctrl_q[`SDMF_CTRL_RL] != 5'h00
                       |=> burst_busy && !bif.beat_valid)
      else $error("pattern burst ignored latency");
endmodule : sdmf_top

// ==== verilog/sdmf_cfg.svh ====
// Constants of the mode feature and calibration readout block
//------------------------------------------------------------------
// Overview of operation
// (RULE_01) Mode two bit 6 enables automatic temperature refresh rate.
// (RULE_02) Automatic rate off: self refresh at single rate.
// (RULE_03) Automatic rate on: double rate above 85 C case temperature.
// (RULE_04) Automatic rate may go double below 85 C, keeping data.
// (RULE_05) Mode two bit 7 enables forced double refresh rate.
// (RULE_06) Forced double rate on: double rate at any temperature.
// (RULE_07) Controller never enables forced and automatic rate together.
// (RULE_08) Up to 95 C controller doubles refreshes, enables a double mode.
// (RULE_09) Mode two bits 10:9 pick write termination; nonzero enables.
// (RULE_10) Write termination replaces nominal for each write burst.
// (RULE_11) Nominal off: high impedance outside writes, write term allowed.
// (RULE_12) No write termination during write leveling.
// (RULE_13) Mode three written only when idle, then update delays waited.
// (RULE_14) Controller programs mode three bit 16 and bits 13:3 zero.
// (RULE_15) Mode three bit 2 low: normal array access, select ignored.
// (RULE_16) Bit 2 high: reads go to pattern register; 00 calibrates.
// (RULE_17) In pattern readout controller issues only reads until cleared.
// (RULE_18) Device reset still works during pattern readout.
// (RULE_19) Pattern on prime lines 0 and 8, others low, or all lines.
// (RULE_20) Readout does eight or chopped four beats, fixed or per command.
// (RULE_21) Controller drives address bits 1:0 zero, bit 2 zero for eight beats.
// (RULE_22) Chopped read: address bit 2 picks beats 0-3 or 4-7; bit 12 chops.
// (RULE_23) Calibration pattern alternates zero and one over the beats.
// (RULE_24) Pattern burst starts after additive plus CAS read latency.
// (RULE_25) Select codes other than 00 are reserved; output is not defined.
//------------------------------------------------------------------
`ifndef SDMF_CFG_SVH
`define SDMF_CFG_SVH
// Register offsets
`define SDMF_OFF_CTRL 8'h00
`define SDMF_OFF_MR2 8'h04
`define SDMF_OFF_MR3 8'h08
`define SDMF_OFF_STAT 8'h0c
`define SDMF_CTRL_RST 32'h0000_80a5
// Control fields
`define SDMF_CTRL_RL 4:0
`define SDMF_CTRL_WL 9:5
`define SDMF_CTRL_BM 11:10
`define SDMF_CTRL_ALL 12
`define SDMF_CTRL_NOM 13
`define SDMF_CTRL_WLVL 14
`define SDMF_CTRL_DLL 15
// Mode register fields
`define SDMF_MR2_ASR 6
`define SDMF_MR2_SRT 7
`define SDMF_MR2_DYN 10:9
`define SDMF_MR3_EN 2
`define SDMF_MR3_SEL 1:0
`define SDMF_SEL_CAL 2'h0
`define SDMF_BA_MR2 3'h2
`define SDMF_BA_MR3 3'h3
`define SDMF_MR_RST 14'h0000
// Command codes on ras, cas, we
`define SDMF_CMD_MRS 3'h0
`define SDMF_CMD_REF 3'h1
`define SDMF_CMD_WR 3'h4
`define SDMF_CMD_RD 3'h5
`define SDMF_A_UPPER 2
`define SDMF_A_BC 12
// Burst modes
`define SDMF_BM_BL8 2'h0
`define SDMF_BM_BC4 2'h1
`define SDMF_BM_OTF 2'h2
`define SDMF_BEATS8 4'h8
`define SDMF_BEATS4 4'h4
`define SDMF_WR_HOLD 5'h04
// Temperatures in degrees C
`define SDMF_TEMP_LIMIT 8'h55
`define SDMF_TEMP_UP 8'h53
`define SDMF_TEMP_DOWN 8'h50
// Termination selections
`define SDMF_TERM_HIZ 2'h0
`define SDMF_TERM_NOM 2'h1
`define SDMF_TERM_WR 2'h2
// Bus answers
`define SDMF_RESP_OKAY 2'h0
`define SDMF_RESP_DECERR 2'h3
`endif

// ==== verilog/sdmf_pkg.sv ====
// Types of the mode feature and calibration readout block
package sdmf_pkg;
   typedef enum logic [1:0] {BST_IDLE, BST_WAIT, BST_BEATS} sdmf_burst_e;
   typedef logic [13:0] sdmf_mr_t;
endpackage : sdmf_pkg

// ==== verilog/sdmf_burst_if.sv ====
// Link between the command logic and the pattern burst engine
`timescale 1ns/10ps
interface sdmf_burst_if;
   logic start;
   logic chop;
   logic upper;
   logic [4:0] lat;
   logic rise;
   logic edge_any;
   logic busy;
   logic beat_valid;
   logic beat_bit;
   modport ctl (output start, chop, upper, lat, rise, edge_any,
                input busy, beat_valid, beat_bit);
   modport gen (input start, chop, upper, lat, rise, edge_any,
                output busy, beat_valid, beat_bit);
endinterface : sdmf_burst_if

// ==== verilog/sdmf_burst.sv ====
// Pattern burst engine: latency wait, then one beat per link edge
`timescale 1ns/10ps
`include "sdmf_cfg.svh"
module sdmf_burst (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Command side
   sdmf_burst_if.gen bus
);
   sdmf_pkg::sdmf_burst_e state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   logic [2:0] beat_q, beat_d;
   logic [3:0] left_q, left_d;
   logic [3:0] len;

   assign len = bus.chop ? `SDMF_BEATS4 : `SDMF_BEATS8;
   assign bus.busy = (state_q != sdmf_pkg::BST_IDLE);
   assign bus.beat_valid = (state_q == sdmf_pkg::BST_BEATS);
   // (RULE_23) alternating pattern bits
   assign bus.beat_bit = beat_q[0];

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      beat_d = beat_q;
      left_d = left_q;
      unique case (state_q)
         sdmf_pkg::BST_IDLE:
         begin
            if (bus.start)
            begin
               // (RULE_22) nibble select on chop
               beat_d = {bus.chop & bus.upper, 2'b00};
               left_d = len;
               cnt_d = bus.lat;
               state_d = (bus.lat == 5'h00) ? sdmf_pkg::BST_BEATS
                                            : sdmf_pkg::BST_WAIT;
            end
         end
         sdmf_pkg::BST_WAIT:
         begin
            // (RULE_24) read latency in link clocks
            if (bus.rise)
            begin
               cnt_d = cnt_q - 5'h01;
               if (cnt_q == 5'h01)
                  state_d = sdmf_pkg::BST_BEATS;
            end
         end
         sdmf_pkg::BST_BEATS:
         begin
            // (RULE_20) eight or four beats
            if (bus.edge_any)
            begin
               beat_d = beat_q + 3'h1;
               left_d = left_q - 4'h1;
               if (left_q == 4'h1)
                  state_d = sdmf_pkg::BST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= sdmf_pkg::BST_IDLE;
         cnt_q <= 5'h00;
         beat_q <= 3'h0;
         left_q <= 4'h0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         beat_q <= beat_d;
         left_q <= left_d;
      end
   end
endmodule : sdmf_burst

// ==== test/sdmf_ctl_model.sv ====
// Memory controller model driving the command pins
`timescale 1ns/10ps
`include "sdmf_cfg.svh"
module sdmf_ctl_model (
   // Command pins, code is {ras, cas, we}
   output logic link_clk_o,
   output logic cke_o,
   output logic cs_n_o,
   output logic [2:0] cmd_o,
   output logic [2:0] ba_o,
   output logic [13:0] addr_o
);
   // ---------------------------------
   // Free running link clock
   // ---------------------------------
   initial
   begin
      {link_clk_o, cke_o, cs_n_o, cmd_o, ba_o, addr_o} =
         {3'h3, 3'h7, 17'h0};
      #37;
      forever #200 link_clk_o = ~link_clk_o;
   end
   // ---------------------------------
   // One command, held a link period
   // ---------------------------------
   task automatic cmd(input logic [2:0] c, input logic [2:0] b,
      input logic [13:0] a, input logic k);
      logic [13:0] m;
   begin
      m = a;
      if (b == `SDMF_BA_MR3) m = a & 14'h0007;
      if (b == `SDMF_BA_MR2) m[6] = m[6] & ~m[7];
      @(negedge link_clk_o);
      {cs_n_o, cmd_o, ba_o, addr_o, cke_o} = {1'b0, c, b, m, k};
      @(negedge link_clk_o);
      // Deselected lines must not keep their last value
      {cs_n_o, cmd_o, ba_o, addr_o} = {1'b1, ~c, ~b, ~m};
      if (c == `SDMF_CMD_MRS) repeat (4) @(negedge link_clk_o);
   end
   endtask : cmd
endmodule : sdmf_ctl_model

// ==== test/sdmf_top_tb_top.sv ====
// Self-checking bench of the mode feature and readout block
`timescale 1ns/10ps
`include "sdmf_cfg.svh"
module sdmf_top_tb_top;
   logic clock_i, rst_n_i, aw_v, w_v, b_r, ar_v, r_r, aw_r, w_r, b_v, ar_r;
   logic r_v, mem_n, on_die_termination, rdbl, sref, arr, lclk, cke, cs_n, seen;
   logic [1:0] b_resp, r_resp, tsel, tcode, resp;
   logic [2:0] ba, cmd;
   logic [7:0] aw_a, ar_a, temp;
   logic [13:0] addr, m2;
   logic [15:0] dq, dq_oe;
   logic [31:0] w_d, r_d, d;
   int n_mismatch, compares, i, k, nb;
   int cyc = 0;
   int n_arr = 0;
   int n_oe = 0;
   // {asr, srt, hot, double}
   logic [3:0] rate_tab [4] = '{4'h2, 4'hb, 4'h8, 4'h5};
   // {burst mode, chop select, a2, all lanes}
   logic [4:0] bst_tab [4] = '{5'h00, 5'h0b, 5'h14, 5'h13};

   sdmf_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .s_axi_awaddr_i(aw_a), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(aw_v),
      .s_axi_awready_o(aw_r), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hf),
      .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_r), .s_axi_bresp_o(b_resp),
      .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a),
      .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_r),
      .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v),
      .s_axi_rready_i(r_r), .link_clk_i(lclk), .dram_reset_n_i(mem_n),
      .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]),
      .we_n_i(cmd[0]), .ba_i(ba), .addr_i(addr), .on_die_termination_i(on_die_termination),
      .case_temp_i(temp), .dq_o(dq), .dq_oe_o(dq_oe),
      .refresh_double_o(rdbl), .self_refresh_o(sref), .term_sel_o(tsel),
      .term_wr_code_o(tcode), .array_read_o(arr));
   sdmf_ctl_model ctl (.link_clk_o(lclk), .cke_o(cke), .cs_n_o(cs_n),
      .cmd_o(cmd), .ba_o(ba), .addr_o(addr));

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] s);
   begin
      compares++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   end
   endtask : chk

   task automatic finish_test;
   begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask : finish_test

   // ---------------------------------
   // Bus master: one write or one read
   // ---------------------------------
   task automatic axi(input logic w, input logic [7:0] a,
      input logic [31:0] v);
      logic ta, tw, tr;
      int n;
   begin
      n = 0;
      tr = 1'b0;
      @(posedge clock_i);
      {aw_a, ar_a, w_d} <= {a, a, v};
      {aw_v, w_v, b_r, ar_v, r_r} <= {w, w, w, !w, !w};
      while (!tr && n < 100)
      begin
         @(negedge clock_i);
         ta = (aw_v & aw_r) | (ar_v & ar_r);
         tw = w_v & w_r;
         tr = (b_v & b_r) | (r_v & r_r);
         d = r_d;
         resp = w ? b_resp : r_resp;
         @(posedge clock_i);
         if (ta) {aw_v, ar_v} <= 2'h0;
         if (tw) w_v <= 1'b0;
         if (tr) {b_r, r_r} <= 2'h0;
         n++;
      end
   end
   endtask : axi

   function automatic logic [31:0] ctrl(input logic [4:0] t, input logic nm,
      input logic wl);
      return {16'h0000, 1'b1, wl, nm, t[0], t[4:3], 5'h03, 5'h02};
   endfunction : ctrl

   // ---------------------------------
   // Pattern burst against queued beats
   // ---------------------------------
   task automatic burst(input int nb, input logic all);
      int n, q[$];
      logic b;
   begin
      for (n = 0; n < nb; n++) q.push_back(n % 2);
      for (n = 0; dq_oe[0] !== 1'b1 && n < 400; n++) @(negedge clock_i);
      repeat (2) @(negedge clock_i);
      for (n = 0; dq_oe[0] === 1'b1 && n < 12; n++)
      begin
         b = (q.size() > 0) ? q.pop_front() : 1'b0;
         chk("beat", all ? {16'h0, {16{b}}} : {23'h0, b, 7'h0, b}, dq);
         repeat (4) @(negedge clock_i);
      end
      chk("beat count", nb, n);
   end
   endtask : burst

   initial
   begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   always @(posedge clock_i)
   begin
      cyc <= cyc + 1;
      if (arr === 1'b1) n_arr <= n_arr + 1;
      if (dq_oe !== 16'h0000) n_oe <= n_oe + 1;
      if (cyc == 30000)
      begin
         n_mismatch++;
         finish_test;
      end
   end

   initial
   begin
      {rst_n_i, aw_v, w_v, b_r, ar_v, r_r, mem_n, on_die_termination} = 8'h03;
      {aw_a, ar_a, w_d, temp} = 56'h19;
      n_mismatch = 0;
      compares = 0;
      void'($urandom(2));
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      axi(1'b0, `SDMF_OFF_CTRL, 32'h0);
      chk("ctrl reset", `SDMF_CTRL_RST, d);
      axi(1'b0, 8'h10, 32'h0);
      chk("unmapped", {30'h0, `SDMF_RESP_DECERR}, {30'h0, resp});
      for (i = 0; i < 4; i++)
      begin
         m2 = {6'h00, rate_tab[i][2], rate_tab[i][3], 6'h00};
         temp <= rate_tab[i][1] ? 8'h56 + 8'($urandom % 40)
                                : 8'($urandom % 80);
         ctl.cmd(`SDMF_CMD_MRS, `SDMF_BA_MR2, m2, 1'b1);
         axi(1'b0, `SDMF_OFF_MR2, 32'h0);
         chk("mode two", {18'h0, m2}, d);
         ctl.cmd(`SDMF_CMD_REF, 3'h0, 14'h0000, 1'b0);
         repeat (8) @(negedge clock_i);
         chk("self refresh", 32'h1, {31'h0, sref});
         chk("double", {31'h0, rate_tab[i][0]}, {31'h0, rdbl});
         ctl.cmd(3'h7, 3'h0, 14'h0000, 1'b1);
      end
      for (i = 0; i < 4; i++)
      begin
         ctl.cmd(`SDMF_CMD_MRS, `SDMF_BA_MR2, {3'h0, 2'(i), 9'h0}, 1'b1);
         chk("term code", i, {30'h0, tcode});
      end
      for (k = 0; k < 3; k++)
      begin
         axi(1'b1, `SDMF_OFF_CTRL, ctrl(5'h0, k != 1, k == 2));
         repeat (4) @(negedge clock_i);
         chk("idle term", {31'h0, k != 1}, {30'h0, tsel});
         ctl.cmd(`SDMF_CMD_WR, 3'h0, 14'h0000, 1'b1);
         seen = 1'b0;
         repeat (80) @(negedge clock_i)
            seen = seen | (tsel === `SDMF_TERM_WR);
         chk("write term", {31'h0, k != 2}, {31'h0, seen});
         chk("restored", {31'h0, k != 1}, {30'h0, tsel});
      end
      // Termination off for reads; only reads while pattern is on
      @(posedge clock_i) on_die_termination <= 1'b0;
      k = n_arr;
      ctl.cmd(`SDMF_CMD_MRS, `SDMF_BA_MR3, 14'h0004, 1'b1);
      for (i = 0; i < 4; i++)
      begin
         axi(1'b1, `SDMF_OFF_CTRL, ctrl(bst_tab[i], 1'b0, 1'b0));
         m2 = {1'b0, bst_tab[i][2], 9'h0, bst_tab[i][1], 2'h0};
         ctl.cmd(`SDMF_CMD_RD, 3'h0, m2, 1'b1);
         nb = (bst_tab[i][4:3] == `SDMF_BM_BL8 || bst_tab[i][2]) ? 8 : 4;
         burst(nb, bst_tab[i][0]);
      end
      chk("array reads", k, n_arr);
      ctl.cmd(`SDMF_CMD_MRS, `SDMF_BA_MR3, 14'h0003, 1'b1);
      nb = n_oe;
      ctl.cmd(`SDMF_CMD_RD, 3'h0, 14'h0000, 1'b1);
      repeat (40) @(negedge clock_i);
      chk("array read", k + 1, n_arr);
      chk("no pattern", nb, n_oe);
      ctl.cmd(`SDMF_CMD_MRS, `SDMF_BA_MR3, 14'h0004, 1'b1);
      ctl.cmd(`SDMF_CMD_RD, 3'h0, 14'h1000, 1'b1);
      repeat (20) @(negedge clock_i);
      @(posedge clock_i) mem_n <= 1'b0;
      repeat (8) @(negedge clock_i);
      chk("oe in reset", 32'h0, {16'h0, dq_oe});
      axi(1'b0, `SDMF_OFF_MR3, 32'h0);
      chk("mode three", 32'h0, d);
      mem_n <= 1'b1;
      finish_test;
   end
endmodule : sdmf_top_tb_top
